// [hdl/sflc_top.v]
// Purpose: Function latch control of a PLL frequency synthesizer.
// Assumes: Serial pins and chip enable are asynchronous to I_REF_CLK.
// Notes: Divider counters live outside; this block drives their resets.
`timescale 1ns/100ps
`include "sflc_consts.vh"
module sflc_top
(
  // Clock and reset.
  input wire I_REF_CLK,
  input wire I_RST,
  // Serial interface pins.
  input wire I_SCLK,
  input wire I_SDATA,
  input wire I_LE,
  // Chip enable pin.
  input wire I_CHIP_EN,
  // Phase detector event pulse from the pump logic, same clock.
  input wire I_PUMP_EVENT,
  // Multiplexer sources, same clock.
  input wire [7:0] I_MUX_SRC,
  // Counter and lock detector control.
  output reg O_REF_CNT_RST,
  output reg O_FB_CNT_RST,
  output reg O_LOCK_DET_RST,
  // Charge pump control.
  output reg O_PUMP_HIZ,
  output reg [2:0] O_PUMP_CURRENT,
  output reg O_FASTLOCK,
  // Power and output pin.
  output reg O_POWERDOWN,
  output reg O_MUX_OUT
);
  wire [`SFLC_WORD_W-1:0] word;
  wire load;
  wire expire;
  reg [1:0] ce_q;
  reg [`SFLC_WORD_W-1:0] func_q;
  reg gain_q;
  reg gain_d;
  reg [2:0] pd_state_q;
  reg [2:0] pd_state_d;
  wire prog_pd;
  wire func_load;
  wire ab_load;
  wire cnt_rst;
  wire pd_arm;
  wire pd_sync;
  wire fl_en;
  wire fl_mode2;
  wire [3:0] tmo_field;
  wire [2:0] mux_sel;
  wire pd_any;
  wire fast_active;
  // One-hot states of the programmed power-down sequencer.
  localparam [2:0] PD_IDLE = 3'h1;
  localparam [2:0] PD_WAIT = 3'h2;
  localparam [2:0] PD_DOWN = 3'h4;
  ////////////////////////////////////////////////////////////////////////////
  sflc_shift_in u_shift
  (
    .i_clk(I_REF_CLK),
    .i_rst(I_RST),
    .i_sclk(I_SCLK),
    .i_sdata(I_SDATA),
    .i_le(I_LE),
    .o_word(word),
    .o_load(load)
  );
  ////////////////////////////////////////////////////////////////////////////
  // The initialization word also writes the function latch.
  assign func_load = load && word[`SFLC_SEL_HI] &&
    (word[`SFLC_SEL_HI:`SFLC_SEL_LO] == `SFLC_SEL_FUNC ||
     word[`SFLC_SEL_HI:`SFLC_SEL_LO] == `SFLC_SEL_INIT);
  assign ab_load = load && (word[`SFLC_SEL_HI:`SFLC_SEL_LO] == `SFLC_SEL_ABCNT);
  assign cnt_rst = func_q[`SFLC_CNT_RST_BIT];
  assign pd_arm = func_q[`SFLC_PD_ARM_BIT];
  assign pd_sync = func_q[`SFLC_PD_SYNC_BIT];
  assign fl_en = func_q[`SFLC_FL_EN_BIT];
  assign fl_mode2 = func_q[`SFLC_FL_MODE_BIT];
  assign tmo_field = func_q[`SFLC_TMO_MSB:`SFLC_TMO_LSB];
  assign mux_sel = func_q[`SFLC_MUX_MSB:`SFLC_MUX_LSB];
  // Chip enable low overrides both programmed bits.
  assign prog_pd = (pd_state_q == PD_DOWN);
  assign pd_any = ~ce_q[1] | prog_pd;
  assign fast_active = fl_en & gain_q;
  ////////////////////////////////////////////////////////////////////////////
  // Chip enable passes two flops; only the second one is read by logic.
  always @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      ce_q <= 2'h0;
    end
    else
    begin
      ce_q <= {ce_q[0], I_CHIP_EN};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      func_q <= `SFLC_FUNC_RESET;
    end
    else if (func_load)
    begin
      func_q <= word;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      gain_q <= 1'b0;
    end
    else
    begin
      gain_q <= gain_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // A host write to the gain bit wins over a timer clear in the same cycle.
  always @*
  begin
    gain_d = gain_q;
    if (fl_en && fl_mode2 && expire)
    begin
      gain_d = 1'b0;
    end
    if (ab_load)
    begin
      gain_d = word[`SFLC_GAIN_BIT];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Programmed power-down; sync mode waits for a pump event so no frequency
  // jump is caused mid-cycle.
  always @*
  begin
    pd_state_d = pd_state_q;
    case (pd_state_q)
      PD_IDLE:
      begin
        if (ce_q[1] && pd_arm)
        begin
          if (!pd_sync || I_PUMP_EVENT)
          begin
            pd_state_d = PD_DOWN;
          end
          else
          begin
            pd_state_d = PD_WAIT;
          end
        end
      end
      PD_WAIT:
      begin
        if (!ce_q[1] || !pd_arm)
        begin
          pd_state_d = PD_IDLE;
        end
        else if (!pd_sync || I_PUMP_EVENT)
        begin
          pd_state_d = PD_DOWN;
        end
      end
      PD_DOWN:
      begin
        if (!ce_q[1] || !pd_arm)
        begin
          pd_state_d = PD_IDLE;
        end
      end
      default:
      begin
        pd_state_d = PD_IDLE;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      pd_state_q <= PD_IDLE;
    end
    else
    begin
      pd_state_q <= pd_state_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // The timer sits at its load value outside mode-2 fastlock, so a stale count never fires.
  sflc_fast_timer u_timer
  (
    .i_clk(I_REF_CLK),
    .i_rst(I_RST),
    .i_load(ab_load),
    .i_run(fast_active & fl_mode2 & ~pd_any),
    .i_tick(I_PUMP_EVENT),
    .i_field(tmo_field),
    .o_expire(expire)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Both resets come from one flop term, so release is simultaneous.
  always @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_REF_CNT_RST <= 1'b1;
      O_FB_CNT_RST <= 1'b1;
    end
    else
    begin
      O_REF_CNT_RST <= cnt_rst | pd_any;
      O_FB_CNT_RST <= cnt_rst | pd_any;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_LOCK_DET_RST <= 1'b1;
      O_POWERDOWN <= 1'b1;
    end
    else
    begin
      O_LOCK_DET_RST <= pd_any;
      O_POWERDOWN <= pd_any;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_PUMP_HIZ <= 1'b1;
    end
    else
    begin
      O_PUMP_HIZ <= pd_any | cnt_rst;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Gain chooses the second current with or without fastlock.
  always @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_PUMP_CURRENT <= 3'h0;
    end
    else if (gain_q)
    begin
      O_PUMP_CURRENT <= func_q[`SFLC_CUR2_MSB:`SFLC_CUR2_LSB];
    end
    else
    begin
      O_PUMP_CURRENT <= func_q[`SFLC_CUR1_MSB:`SFLC_CUR1_LSB];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_FASTLOCK <= 1'b0;
    end
    else
    begin
      O_FASTLOCK <= fast_active & ~pd_any;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // The pin is taken from a flop so a select change never glitches it.
  always @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_MUX_OUT <= 1'b0;
    end
    else
    begin
      O_MUX_OUT <= I_MUX_SRC[mux_sel];
    end
  end
endmodule

// [hdl/sflc_consts.vh]
// Purpose: Constants for the synthesizer function latch control block.
// Assumes: 24-bit serial words, control bits in the two lowest positions.
// Notes: Bit positions are those of the programming word.
`ifndef SFLC_CONSTS_VH
`define SFLC_CONSTS_VH
`define SFLC_WORD_W 24
`define SFLC_SEL_HI 1
`define SFLC_SEL_LO 0
`define SFLC_SEL_RCNT 2'h0
`define SFLC_SEL_ABCNT 2'h1
`define SFLC_SEL_FUNC 2'h2
`define SFLC_SEL_INIT 2'h3
`define SFLC_CNT_RST_BIT 2
`define SFLC_PD_ARM_BIT 3
`define SFLC_MUX_LSB 4
`define SFLC_MUX_MSB 6
`define SFLC_FL_EN_BIT 9
`define SFLC_FL_MODE_BIT 10
`define SFLC_TMO_LSB 11
`define SFLC_TMO_MSB 14
`define SFLC_CUR1_LSB 15
`define SFLC_CUR1_MSB 17
`define SFLC_CUR2_LSB 18
`define SFLC_CUR2_MSB 20
`define SFLC_PD_SYNC_BIT 21
`define SFLC_GAIN_BIT 21
`define SFLC_FUNC_RESET 24'h000000
`define SFLC_TMO_UNIT 4'h4
`endif

// [hdl/sflc_shift_in.v]
// Purpose: Three-wire serial input register for the function latch control.
// Assumes: Clock, data and load-enable pins are asynchronous to the reference clock.
// Notes: Runs regardless of power-down so programming is always possible.
`timescale 1ns/100ps
`include "sflc_consts.vh"
module sflc_shift_in
(
  // Clock and reset.
  input wire i_clk,
  input wire i_rst,
  // Serial pins.
  input wire i_sclk,
  input wire i_sdata,
  input wire i_le,
  // Latched word.
  output reg [`SFLC_WORD_W-1:0] o_word,
  output reg o_load
);
  reg [2:0] sclk_q;
  reg [2:0] le_q;
  reg [1:0] dat_q;
  reg [`SFLC_WORD_W-1:0] shift_q;
  wire sclk_rise;
  wire le_rise;
  assign sclk_rise = sclk_q[1] & ~sclk_q[2];
  assign le_rise = le_q[1] & ~le_q[2];
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sclk_q <= 3'h0;
      le_q <= 3'h0;
      dat_q <= 2'h0;
      shift_q <= 24'h000000;
      o_word <= 24'h000000;
      o_load <= 1'b0;
    end
    else
    begin
      sclk_q <= {sclk_q[1:0], i_sclk};
      le_q <= {le_q[1:0], i_le};
      dat_q <= {dat_q[0], i_sdata};
      o_load <= 1'b0;
      // Shifting never depends on power-down state.
      if (sclk_rise)
      begin
        shift_q <= {shift_q[`SFLC_WORD_W-2:0], dat_q[1]};
      end
      if (le_rise)
      begin
        o_word <= shift_q;
        o_load <= 1'b1;
      end
    end
  end
endmodule

// [hdl/sflc_fast_timer.v]
// Purpose: Fastlock timeout counter.
// Assumes: One tick per phase-detector event.
// Notes: Timeout length is the field value times 16, plus one fixed unit of 4.
`timescale 1ns/100ps
`include "sflc_consts.vh"
module sflc_fast_timer
(
  // Clock and reset.
  input wire i_clk,
  input wire i_rst,
  // Control.
  input wire i_load,
  input wire i_run,
  input wire i_tick,
  input wire [3:0] i_field,
  // Status.
  output reg o_expire
);
  reg [7:0] cnt_q;
  wire [7:0] start_val;
  assign start_val = {i_field, 4'h0} + {4'h0, `SFLC_TMO_UNIT};
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_q <= 8'h00;
      o_expire <= 1'b0;
    end
    else
    begin
      o_expire <= 1'b0;
      // Held at load state while asked to, including any power-down.
      if (i_load || !i_run)
      begin
        cnt_q <= start_val;
      end
      else if (i_tick)
      begin
        if (cnt_q == 8'h01)
        begin
          o_expire <= 1'b1;
          cnt_q <= start_val;
        end
        else
        begin
          cnt_q <= cnt_q - 8'h01;
        end
      end
    end
  end
endmodule

// [tb/sflc_host.sv]
// Purpose: Host model writing words over the three-wire serial pins.
// Assumes: Each pin level is held three reference clocks or more.
// Notes: Data is inverted after the last bit so a stale level is never read.
`timescale 1ns/100ps
module sflc_host
(
  // Clock.
  input wire i_clk,
  // Serial pins.
  output reg o_sclk,
  output reg o_sdata,
  output reg o_le
);
  initial {o_sclk, o_sdata, o_le} = 3'h0;
  task send(input [23:0] w);
    integer i;
    begin
      for (i = 23; i >= 0; i = i - 1)
      begin
        @(posedge i_clk) {o_sclk, o_sdata} <= {1'b0, w[i]};
        repeat (3) @(posedge i_clk);
        o_sclk <= 1'b1;
        repeat (3) @(posedge i_clk);
      end
      {o_le, o_sdata} <= {1'b1, ~w[0]};
      repeat (4) @(posedge i_clk);
      o_le <= 1'b0;
      repeat (8) @(posedge i_clk);
      @(negedge i_clk);
    end
  endtask
endmodule

// [tb/sflc_top_chk.sv]
// Purpose: Port checker for the function latch control.
// Assumes: Single clock domain.
// Notes: Mux checks use all-equal sources so the select need not be known.
`timescale 1ns/100ps
module sflc_top_chk
(
  input wire I_REF_CLK,
  input wire I_RST,
  input wire I_CHIP_EN,
  input wire [7:0] I_MUX_SRC,
  input wire O_REF_CNT_RST,
  input wire O_FB_CNT_RST,
  input wire O_LOCK_DET_RST,
  input wire O_PUMP_HIZ,
  input wire O_FASTLOCK,
  input wire O_POWERDOWN,
  input wire O_MUX_OUT
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  a_fb_ref_equal: assert property (O_FB_CNT_RST == O_REF_CNT_RST) else $error("cnt rst");
  a_pd_load_state: assert property (O_POWERDOWN |-> O_REF_CNT_RST) else $error("pd load");
  a_pd_pump_hiz: assert property (O_POWERDOWN |-> O_PUMP_HIZ) else $error("pd hiz");
  a_pd_lock_rst: assert property (O_POWERDOWN |-> O_LOCK_DET_RST) else $error("pd lock");
  a_pd_no_fast: assert property (O_POWERDOWN |-> !O_FASTLOCK) else $error("pd fast");
  a_ce_low_pd: assert property (!I_CHIP_EN [*5] |-> O_POWERDOWN) else $error("ce pd");
  a_mux_all_one: assert property (&I_MUX_SRC |=> O_MUX_OUT) else $error("mux one");
  a_mux_all_zero: assert property (~|I_MUX_SRC |=> !O_MUX_OUT) else $error("mux zero");
endmodule
bind sflc_top sflc_top_chk sflc_top_chk_inst (.I_REF_CLK, .I_RST, .I_CHIP_EN, .I_MUX_SRC,
  .O_REF_CNT_RST, .O_FB_CNT_RST, .O_LOCK_DET_RST, .O_PUMP_HIZ, .O_FASTLOCK, .O_POWERDOWN,
  .O_MUX_OUT);

// [tb/sflc_top_test.sv]
// Purpose: Directed test of the function latch control.
// Assumes: Timeout is field times 16 plus 4 pump events.
// Notes: Checks sample at the falling edge, away from output updates.
`timescale 1ns/100ps
module sflc_top_test;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg ce = 1'b1;
  reg ev = 1'b0;
  reg [7:0] src = 8'h5a;
  wire sclk, sdata, le, cr, fr, lr, hz, fl, pd, mx;
  wire [2:0] cur;
  integer errors = 0;
  integer check_count = 0;
  always #5 clk = ~clk;
  sflc_host sflc_host_inst (.i_clk(clk), .o_sclk(sclk), .o_sdata(sdata), .o_le(le));
  sflc_top sflc_top_inst (.I_REF_CLK(clk), .I_RST(rst), .I_SCLK(sclk), .I_SDATA(sdata),
    .I_LE(le), .I_CHIP_EN(ce), .I_PUMP_EVENT(ev), .I_MUX_SRC(src), .O_REF_CNT_RST(cr),
    .O_FB_CNT_RST(fr), .O_LOCK_DET_RST(lr), .O_PUMP_HIZ(hz), .O_PUMP_CURRENT(cur),
    .O_FASTLOCK(fl), .O_POWERDOWN(pd), .O_MUX_OUT(mx));
  // Current setting 1 is 1 and setting 2 is 6 in every function word.
  function [23:0] fw(input [3:0] t, input m, e, input [2:0] x, input a, c, s);
    fw = {2'h0, s, 3'h6, 3'h1, t, m, e, 2'h0, x, a, c, 2'h2};
  endfunction
  function [23:0] ab(input g);
    ab = {2'h0, g, 19'h0, 2'h1};
  endfunction
  task chk(input [8*4:1] n, input [2:0] e, input [2:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e)
      begin
        errors = errors + 1;
        $display("[FAIL] %0s expected %0h seen %0h", n, e, g);
      end
    end
  endtask
  task pulse(input integer n);
    repeat (n)
    begin
      @(posedge clk) ev <= 1'b1;
      @(posedge clk) ev <= 1'b0;
    end
  endtask
  task settle(input integer n);
    begin
      repeat (n) @(posedge clk);
      @(negedge clk);
    end
  endtask
  task test_done;
    begin
      if (errors == 0 && check_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial
  begin
    #100000;
    errors = errors + 1;
    test_done;
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    sflc_host_inst.send(fw(4'h0, 1'b1, 1'b1, 3'h3, 1'b0, 1'b0, 1'b0));
    chk("pd", 3'h0, {2'h0, pd});
    chk("mux", 3'h1, {2'h0, mx});
    chk("cur", 3'h1, cur);
    sflc_host_inst.send(ab(1'b1));
    chk("fl", 3'h1, {2'h0, fl});
    chk("cur", 3'h6, cur);
    pulse(3);
    settle(0);
    chk("fl", 3'h1, {2'h0, fl});
    pulse(1);
    settle(3);
    chk("fl", 3'h0, {2'h0, fl});
    chk("cur", 3'h1, cur);
    sflc_host_inst.send(fw(4'h1, 1'b1, 1'b1, 3'h3, 1'b0, 1'b0, 1'b0));
    sflc_host_inst.send(ab(1'b1));
    pulse(19);
    settle(0);
    chk("fl", 3'h1, {2'h0, fl});
    pulse(1);
    settle(3);
    chk("fl", 3'h0, {2'h0, fl});
    sflc_host_inst.send(fw(4'h0, 1'b0, 1'b1, 3'h2, 1'b0, 1'b0, 1'b0));
    chk("mux", 3'h0, {2'h0, mx});
    sflc_host_inst.send(ab(1'b1));
    pulse(8);
    settle(0);
    chk("fl", 3'h1, {2'h0, fl});
    sflc_host_inst.send(ab(1'b0));
    chk("fl", 3'h0, {2'h0, fl});
    sflc_host_inst.send(fw(4'h0, 1'b0, 1'b0, 3'h3, 1'b0, 1'b0, 1'b0));
    sflc_host_inst.send(ab(1'b1));
    chk("fl", 3'h0, {2'h0, fl});
    chk("cur", 3'h6, cur);
    sflc_host_inst.send(fw(4'h0, 1'b0, 1'b0, 3'h3, 1'b0, 1'b1, 1'b0));
    chk("crst", 3'h1, {2'h0, cr});
    chk("hiz", 3'h1, {2'h0, hz});
    sflc_host_inst.send(fw(4'h0, 1'b0, 1'b0, 3'h3, 1'b0, 1'b0, 1'b0));
    chk("frst", 3'h0, {2'h0, fr});
    chk("crst", 3'h0, {2'h0, cr});
    sflc_host_inst.send(fw(4'h0, 1'b0, 1'b0, 3'h3, 1'b1, 1'b0, 1'b0));
    chk("pd", 3'h1, {2'h0, pd});
    chk("lock", 3'h1, {2'h0, lr});
    sflc_host_inst.send(fw(4'h0, 1'b0, 1'b0, 3'h3, 1'b0, 1'b0, 1'b0));
    chk("pd", 3'h0, {2'h0, pd});
    sflc_host_inst.send(fw(4'h0, 1'b0, 1'b0, 3'h3, 1'b1, 1'b0, 1'b0) & 24'hfffffc);
    chk("pd", 3'h0, {2'h0, pd});
    sflc_host_inst.send(fw(4'h0, 1'b0, 1'b0, 3'h3, 1'b1, 1'b0, 1'b1));
    chk("pd", 3'h0, {2'h0, pd});
    pulse(1);
    settle(2);
    chk("pd", 3'h1, {2'h0, pd});
    chk("hiz", 3'h1, {2'h0, hz});
    sflc_host_inst.send(fw(4'h0, 1'b0, 1'b0, 3'h3, 1'b0, 1'b0, 1'b0));
    @(posedge clk) ce <= 1'b0;
    settle(5);
    chk("pd", 3'h1, {2'h0, pd});
    chk("frst", 3'h1, {2'h0, fr});
    @(posedge clk) ce <= 1'b1;
    settle(5);
    chk("pd", 3'h0, {2'h0, pd});
    @(posedge clk) src <= 8'hff;
    settle(3);
    chk("mux", 3'h1, {2'h0, mx});
    @(posedge clk) src <= 8'h00;
    settle(3);
    chk("mux", 3'h0, {2'h0, mx});
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle(4);
    chk("cur", 3'h0, cur);
    chk("pd", 3'h0, {2'h0, pd});
    test_done;
  end
endmodule
